// File: core/fpsc_pkg.sv
`default_nettype none
package fpsc_pkg;
  // clock and link rates
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BAUD_DIV_CYC  = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned TIMER_HZ      = 1000;
  localparam int unsigned TIMER_DIV_CYC = CLK_HZ / TIMER_HZ;

  // settling time after a row or mux change, least time so rounded up
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [8:0]  SETTLE_LOAD   = 9'(SETTLE_CYC - 1);

  // matrix and analog geometry
  localparam int unsigned ROWS          = 9;
  localparam int unsigned COLS          = 8;
  localparam int unsigned POTS          = 10;
  localparam int unsigned PROBES        = 4;
  localparam int unsigned LEDS          = 5;
  localparam int unsigned BANK_A_CH     = 8;

  // report tags, first byte of each two-byte report
  localparam logic [7:0]  TAG_SWITCH    = 8'h01;
  localparam logic [7:0]  TAG_POT       = 8'h20;
  localparam logic [7:0]  TAG_PROBE     = 8'h40;

  // probe code thresholds on the 8-bit conversion
  localparam logic [7:0]  PROBE_TH1     = 8'h40;
  localparam logic [7:0]  PROBE_TH2     = 8'h80;
  localparam logic [7:0]  PROBE_TH3     = 8'hC0;

  // led latch: reset value (all dark) and latch bit of each led id
  localparam logic [7:0]  LED_RESET     = 8'hFF;
  localparam logic [2:0]  LED_SLOT0     = 3'h0;
  localparam logic [2:0]  LED_SLOT1     = 3'h1;
  localparam logic [2:0]  LED_SLOT2     = 3'h2;
  localparam logic [2:0]  LED_SLOT3     = 3'h3;
  localparam logic [2:0]  LED_SLOT4     = 3'h4;

  typedef enum logic [2:0] {
    ST_ROW   = 3'b000,
    ST_COL   = 3'b001,
    ST_ADC   = 3'b011,
    ST_WAIT  = 3'b010,
    ST_EVAL  = 3'b110,
    ST_SEND0 = 3'b111,
    ST_SEND1 = 3'b101
  } fpsc_state_t;

  typedef enum logic [1:0] {
    PH_SWITCH = 2'b00,
    PH_POT    = 2'b01,
    PH_PROBE  = 2'b11
  } fpsc_phase_t;
endpackage
`default_nettype wire

// File: core/fpsc_uart.sv
`default_nettype none
module fpsc_uart #(
  parameter int unsigned BAUD_DIV = fpsc_pkg::BAUD_DIV_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // transmit byte
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // receive byte
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  // serial pins
  output logic            txd,
  input  wire logic       rxd
);
  localparam int unsigned CW = $clog2(BAUD_DIV + 1);
  localparam logic [CW-1:0] DIV_LOAD  = CW'(BAUD_DIV - 1);
  localparam logic [CW-1:0] HALF_LOAD = CW'(BAUD_DIV / 2);

  logic [9:0]    tx_sh_r;
  logic [3:0]    tx_cnt_r;
  logic [CW-1:0] tx_div_r;
  logic [8:0]    rx_sh_r;
  logic [3:0]    rx_cnt_r;
  logic [CW-1:0] rx_div_r;
  logic          rx_valid_r;
  logic [7:0]    rx_data_r;

  wire tx_take = tx_ready && tx_valid;
  wire tx_tick = tx_div_r == '0;
  wire rx_tick = rx_div_r == '0;

  assign tx_ready = tx_cnt_r == 4'h0;
  assign txd      = tx_sh_r[0];
  assign rx_valid = rx_valid_r;
  assign rx_data  = rx_data_r;

  // 8N1 frame: start bit, eight data bits lsb first, stop bit
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_r  <= '1;
      tx_cnt_r <= 4'h0;
      tx_div_r <= '0;
    end else if (tx_take) begin
      tx_sh_r  <= {1'b1, tx_data, 1'b0};
      tx_cnt_r <= 4'hA;
      tx_div_r <= DIV_LOAD;
    end else if (tx_cnt_r != 4'h0) begin
      tx_div_r <= tx_tick ? DIV_LOAD : tx_div_r - 1'b1;
      if (tx_tick) begin
        tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end
    end
  end

  // sampling mid-bit; a start bit that is high again at its centre is a glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_sh_r    <= '0;
      rx_cnt_r   <= 4'h0;
      rx_div_r   <= '0;
      rx_valid_r <= 1'b0;
      rx_data_r  <= 8'h00;
    end else begin
      rx_valid_r <= 1'b0;
      if (rx_cnt_r == 4'h0) begin
        if (!rxd) begin
          rx_cnt_r <= 4'hA;
          rx_div_r <= HALF_LOAD;
        end
      end else if (!rx_tick) begin
        rx_div_r <= rx_div_r - 1'b1;
      end else begin
        rx_div_r <= DIV_LOAD;
        rx_cnt_r <= rx_cnt_r - 4'h1;
        if (rx_cnt_r != 4'h1) begin
          rx_sh_r <= {rxd, rx_sh_r[8:1]};
        end
        if (rx_cnt_r == 4'hA && rxd) begin
          rx_cnt_r <= 4'h0;
        end
        if (rx_cnt_r == 4'h1 && rxd) begin
          rx_valid_r <= 1'b1;
          rx_data_r  <= rx_sh_r[8:1];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/fpsc_timer.sv
`default_nettype none
module fpsc_timer #(
  parameter int unsigned DIV = fpsc_pkg::TIMER_DIV_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // compare channels
  output logic      compare_output_one,
  output logic      compare_output_two
);
  localparam int unsigned CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST    = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF    = CW'(DIV / 2);
  localparam logic [CW-1:0] QUARTER = CW'(DIV / 4);
  localparam logic [CW-1:0] Q3      = CW'(DIV / 4 + DIV / 2);

  logic [CW-1:0] cnt_r;
  logic          one_r;
  logic          two_r;

  wire one_nxt = cnt_r < HALF;
  // second channel runs a quarter period behind so the edges never coincide
  wire two_nxt = (cnt_r >= QUARTER) && (cnt_r < Q3);

  assign compare_output_one = one_r;
  assign compare_output_two = two_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      one_r <= 1'b0;
      two_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      one_r <= one_nxt;
      two_r <= two_nxt;
    end
  end
endmodule
`default_nettype wire

// File: core/fpsc_panel_controller.sv
// Functional notes
// - switches form a nine-row by eight-column matrix, one switch per crossing
// - rows are driven low one at a time; all eight columns sampled per row
// - a low column while its row is low means that switch is closed
// - each switch is compared with its stored state; only changes are reported
// - first compare channel gives the 1 kHz probe compensation square wave
// - second compare channel gives a 1 kHz output used as analog_jitter_ref reference
// - mux select lines choose pot inputs or probe-code inputs per scan step
// - pot scan selects one of ten inputs over two muxes and converts it
// - pot change magnitude and direction is reported; the new reading is stored as the report is built
// - four endless knobs give two wiper inputs each; two stopped knobs one each
// - probe scan selects one of four codes on first mux, classifies, reports
// - host led id maps to one bit of the 8-bit latch; only it changes
// - host link is asynchronous 8N1 at 9600 baud
`default_nettype none
module fpsc_panel_controller #(
  parameter int unsigned BAUD_DIV  = fpsc_pkg::BAUD_DIV_CYC,
  parameter int unsigned TIMER_DIV = fpsc_pkg::TIMER_DIV_CYC
) (
  // clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RST,

  // switch matrix
  output logic [fpsc_pkg::ROWS-1:0]        ROW_DRIVE_N,
  input  wire logic [fpsc_pkg::COLS-1:0]   COL_SENSE_N,

  // analog mux and converter
  output logic                             MUX_PROBE_MODE,
  output logic                             MUX_BANK,
  output logic [2:0]                       MUX_CH,
  output logic                             ADC_START,
  input  wire logic                        ADC_DONE,
  input  wire logic [7:0]                  ADC_RESULT,

  // host serial link
  output logic                             TXD,
  input  wire logic                        RXD,

  // led latch
  output logic [7:0]                       LED_LATCH,

  // timer outputs
  output logic                             PROBE_COMP_SQUARE,
  output logic                             ANALOG_JITTER_REF
);
  import fpsc_pkg::*;

  function automatic logic [7:0] pot_delta(input logic [7:0] now, input logic [7:0] old);
    logic [7:0] mag;
    mag = (now >= old) ? now - old : old - now;
    // the reading is stored whole, so saturating only clips one report
    return {now < old, mag[7] ? 7'h7F : mag[6:0]};
  endfunction

  function automatic logic [1:0] probe_class(input logic [7:0] v);
    if (v < PROBE_TH1) return 2'h0;
    if (v < PROBE_TH2) return 2'h1;
    if (v < PROBE_TH3) return 2'h2;
    return 2'h3;
  endfunction

  function automatic logic [2:0] led_slot(input logic [2:0] id);
    unique case (id)
      3'h0:    return LED_SLOT0;
      3'h1:    return LED_SLOT1;
      3'h2:    return LED_SLOT2;
      3'h3:    return LED_SLOT3;
      default: return LED_SLOT4;
    endcase
  endfunction

  fpsc_state_t state_r;
  fpsc_state_t state_nxt;
  fpsc_phase_t phase_r;

  logic [3:0]            row_r;
  logic [2:0]            col_r;
  logic [3:0]            ch_r;
  logic [8:0]            settle_r;
  logic [COLS-1:0]       closed_r;
  logic [ROWS*COLS-1:0]  sw_state_r;

  logic [7:0]            pot_r [POTS];
  logic [1:0]            probe_r [PROBES];
  logic [PROBES-1:0]     probe_seen_r;

  logic [7:0]            sample_r;
  logic [7:0]            msg0_r;
  logic [7:0]            msg1_r;
  logic [7:0]            led_r;

  logic                  tx_ready;
  logic [7:0]            rx_data;
  logic                  rx_valid;

  // decode
  wire       settle_done = settle_r == 9'h000;

  // switch walk
  wire [6:0] sw_idx      = {row_r, col_r};
  wire       sw_now      = closed_r[col_r];
  wire       sw_changed  = sw_now != sw_state_r[sw_idx];
  wire       col_last    = col_r == 3'(COLS - 1);
  wire       row_last    = row_r == 4'(ROWS - 1);

  // analog walk and report decision
  wire       is_pot      = phase_r == PH_POT;
  wire       ch_last     = is_pot ? (ch_r == 4'(POTS - 1)) : (ch_r == 4'(PROBES - 1));
  wire [7:0] pot_d       = pot_delta(sample_r, pot_r[ch_r]);
  wire       pot_moved   = pot_d[6:0] != 7'h00;
  wire [1:0] probe_cls   = probe_class(sample_r);
  wire [1:0] pr_idx      = ch_r[1:0];
  wire       probe_new   = !probe_seen_r[pr_idx] || (probe_r[pr_idx] != probe_cls);
  wire       eval_report = is_pot ? pot_moved : probe_new;

  // report bytes to the transmitter
  wire       tx_valid    = (state_r == ST_SEND0) || (state_r == ST_SEND1);
  wire [7:0] tx_data     = (state_r == ST_SEND0) ? msg0_r : msg1_r;

  // a new row or channel reloads the settle counter
  wire       entering    = (state_nxt != state_r) &&
                           ((state_nxt == ST_ROW) || (state_nxt == ST_ADC));
  // runs down to zero and holds there until the next reload
  wire [8:0] settle_nxt  = entering ? SETTLE_LOAD :
                           (settle_done ? settle_r : settle_r - 9'h001);

  // led command decode
  wire       led_write   = rx_valid && (rx_data[2:0] < 3'(LEDS));
  wire [2:0] led_bit     = led_slot(rx_data[2:0]);

  // one row low at a time while the switch phase owns the matrix
  assign ROW_DRIVE_N    = (phase_r == PH_SWITCH) ? ~(ROWS'(1) << row_r) : '1;

  // pots 0..7 on bank A, 8..9 on bank B; probes always bank A
  assign MUX_PROBE_MODE = phase_r == PH_PROBE;
  assign MUX_BANK       = is_pot && (ch_r >= 4'(BANK_A_CH));
  assign MUX_CH         = MUX_BANK ? 3'(ch_r - 4'(BANK_A_CH)) : ch_r[2:0];

  assign ADC_START      = (state_r == ST_ADC) && settle_done;
  assign LED_LATCH      = led_r;

  // scan sequencer; the converter has no timeout, so a dead one stalls the scan
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ROW: begin
        if (settle_done) state_nxt = ST_COL;
      end

      ST_COL: begin
        if (sw_changed) begin
          state_nxt = ST_SEND0;
        end else if (col_last && row_last) begin
          state_nxt = ST_ADC;
        end else if (col_last) begin
          state_nxt = ST_ROW;
        end
      end

      ST_ADC: begin
        if (settle_done) state_nxt = ST_WAIT;
      end

      ST_WAIT: begin
        if (ADC_DONE) state_nxt = ST_EVAL;
      end

      ST_EVAL: begin
        if (eval_report) begin
          state_nxt = ST_SEND0;
        end else if (ch_last && !is_pot) begin
          state_nxt = ST_ROW;
        end else begin
          state_nxt = ST_ADC;
        end
      end

      ST_SEND0: begin
        if (tx_ready) state_nxt = ST_SEND1;
      end

      ST_SEND1: begin
        if (tx_ready) state_nxt = (phase_r == PH_SWITCH) ? ST_COL : ST_EVAL;
      end

      default:  state_nxt = ST_ROW;
    endcase
  end

  // sequencer state and settle countdown
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r  <= ST_ROW;
      settle_r <= SETTLE_LOAD;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // switch scan; the stored bit is updated before the report goes out, so the
  // return to ST_COL sees no change and moves on
  always_ff @(posedge MCLK) begin
    if (RST) begin
      closed_r   <= '0;
      sw_state_r <= '0;
      row_r      <= 4'h0;
      col_r      <= 3'h0;
    end else if (state_r == ST_ROW && settle_done) begin
      closed_r <= ~COL_SENSE_N;
    end else if (state_r == ST_COL) begin
      if (sw_changed) begin
        sw_state_r[sw_idx] <= sw_now;
      end else if (col_last) begin
        col_r <= 3'h0;
        row_r <= row_last ? 4'h0 : row_r + 4'h1;
      end else begin
        col_r <= col_r + 3'h1;
      end
    end
  end

  // analog scan and report assembly
  always_ff @(posedge MCLK) begin
    if (RST) begin
      phase_r      <= PH_SWITCH;
      ch_r         <= 4'h0;
      sample_r     <= 8'h00;
      pot_r        <= '{default: 8'h00};
      probe_r      <= '{default: 2'h0};
      probe_seen_r <= '0;
      msg0_r       <= 8'h00;
      msg1_r       <= 8'h00;
    end else begin
      if (state_r == ST_COL && sw_changed) begin
        msg0_r <= TAG_SWITCH;
        msg1_r <= {sw_now, sw_idx};
      end

      if (state_r == ST_COL && !sw_changed && col_last && row_last) begin
        phase_r <= PH_POT;
        ch_r    <= 4'h0;
      end

      if (state_r == ST_WAIT && ADC_DONE) begin
        sample_r <= ADC_RESULT;
      end

      if (state_r == ST_EVAL && eval_report && is_pot) begin
        pot_r[ch_r] <= sample_r;
        msg0_r      <= TAG_POT | {4'h0, ch_r};
        msg1_r      <= pot_d;
      end

      if (state_r == ST_EVAL && eval_report && !is_pot) begin
        probe_r[pr_idx]      <= probe_cls;
        probe_seen_r[pr_idx] <= 1'b1;
        msg0_r               <= TAG_PROBE | {6'h00, pr_idx};
        msg1_r               <= {6'h00, probe_cls};
      end

      if (state_r == ST_EVAL && !eval_report) begin
        ch_r <= ch_last ? 4'h0 : ch_r + 4'h1;
        if (ch_last) begin
          phase_r <= is_pot ? PH_PROBE : PH_SWITCH;
        end
      end
    end
  end

  // led latch; a set bit is dark because the led sinks into the latch
  always_ff @(posedge MCLK) begin
    if (RST) begin
      led_r <= LED_RESET;
    end else if (led_write) begin
      led_r[led_bit] <= ~rx_data[7];
    end
  end

  fpsc_uart #(
    .BAUD_DIV (BAUD_DIV)
  ) u_uart (
    .clk      (MCLK),
    .rst      (RST),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .txd      (TXD),
    .rxd      (RXD)
  );

  fpsc_timer #(
    .DIV (TIMER_DIV)
  ) u_timer (
    .clk                (MCLK),
    .rst                (RST),
    .compare_output_one (PROBE_COMP_SQUARE),
    .compare_output_two (ANALOG_JITTER_REF)
  );
endmodule
`default_nettype wire

// File: test/fpsc_panel_controller_properties.sv
`default_nettype none
module fpsc_checker #(
  parameter int unsigned BAUD_DIV  = 16,
  parameter int unsigned TIMER_DIV = 40
) (
  // clock and reset
  input wire logic                      MCLK,
  input wire logic                      RST,
  // matrix and analog
  input wire logic [fpsc_pkg::ROWS-1:0] ROW_DRIVE_N,
  input wire logic [fpsc_pkg::COLS-1:0] COL_SENSE_N,
  input wire logic                      MUX_PROBE_MODE,
  input wire logic                      MUX_BANK,
  input wire logic [2:0]                MUX_CH,
  input wire logic                      ADC_START,
  input wire logic                      ADC_DONE,
  input wire logic [7:0]                ADC_RESULT,
  // link, latch, timers
  input wire logic                      TXD,
  input wire logic                      RXD,
  input wire logic [7:0]                LED_LATCH,
  input wire logic                      PROBE_COMP_SQUARE,
  input wire logic                      ANALOG_JITTER_REF
);
  import fpsc_pkg::*;
  localparam int HALF = TIMER_DIV / 2;
  localparam int QLO  = TIMER_DIV / 4 - 1;
  localparam int QHI  = TIMER_DIV / 4 + 1;
  localparam int BLST = BAUD_DIV - 8;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [7:0]  mux_age_r;
  logic [15:0] half_cnt_r;
  logic        half_seen_r;
  // age saturates so a long switch phase never wraps back under the settle figure
  always_ff @(posedge MCLK) begin
    if (RST || $changed({MUX_PROBE_MODE, MUX_BANK, MUX_CH})) mux_age_r <= 8'h00;
    else if (mux_age_r != 8'hFF) mux_age_r <= mux_age_r + 8'h01;
  end
  always_ff @(posedge MCLK) begin
    if (RST) half_seen_r <= 1'b0;
    else if ($changed(PROBE_COMP_SQUARE)) half_seen_r <= 1'b1;
    if (RST || $changed(PROBE_COMP_SQUARE)) half_cnt_r <= 16'h0000;
    else half_cnt_r <= half_cnt_r + 16'h0001;
  end
  sequence low_bit_s;
    (!TXD) [*8] ##[BLST:BLST] !TXD;
  endsequence
  sequence jit_rise_s;
    ##[QLO:QHI] $rose(ANALOG_JITTER_REF);
  endsequence
  a_row_single: assert property ($countones(~ROW_DRIVE_N) <= 1)
    else $error("more than one row driven");
  a_row_hold: assert property ($changed(ROW_DRIVE_N) && !(&ROW_DRIVE_N) |=>
    $stable(ROW_DRIVE_N) [*8]) else $error("row dropped early");
  a_adc_rowidle: assert property (ADC_START |-> &ROW_DRIVE_N)
    else $error("conversion during switch scan");
  a_adc_settle: assert property (ADC_START |-> mux_age_r >= 8'(SETTLE_CYC - 3))
    else $error("conversion before mux settled");
  a_adc_pulse: assert property (ADC_START |=> !ADC_START)
    else $error("start longer than one cycle");
  a_pot_bank: assert property (!MUX_PROBE_MODE && MUX_BANK |-> MUX_CH <= 3'h1)
    else $error("bad second bank channel");
  a_probe_mux: assert property (MUX_PROBE_MODE |-> !MUX_BANK && MUX_CH <= 3'h3)
    else $error("bad probe channel");
  a_led_spare: assert property (LED_LATCH[7:5] == 3'b111)
    else $error("spare latch bit driven");
  a_reset_vals: assert property ($fell(RST) |-> TXD && LED_LATCH == LED_RESET)
    else $error("bad values after reset");
  a_comp_half: assert property (half_seen_r && $changed(PROBE_COMP_SQUARE) |->
    half_cnt_r == 16'(HALF - 1)) else $error("compensation half period wrong");
  a_jitter_qtr: assert property ($rose(PROBE_COMP_SQUARE) |-> jit_rise_s)
    else $error("second timer phase wrong");
  a_bit_len: assert property ($fell(TXD) |-> low_bit_s)
    else $error("serial bit too short");
endmodule
bind fpsc_panel_controller fpsc_checker #(.BAUD_DIV(BAUD_DIV), .TIMER_DIV(TIMER_DIV)) chk_u (
  .MCLK(MCLK), .RST(RST), .ROW_DRIVE_N(ROW_DRIVE_N), .COL_SENSE_N(COL_SENSE_N),
  .MUX_PROBE_MODE(MUX_PROBE_MODE), .MUX_BANK(MUX_BANK), .MUX_CH(MUX_CH),
  .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_RESULT(ADC_RESULT), .TXD(TXD),
  .RXD(RXD), .LED_LATCH(LED_LATCH), .PROBE_COMP_SQUARE(PROBE_COMP_SQUARE),
  .ANALOG_JITTER_REF(ANALOG_JITTER_REF));
`default_nettype wire

// File: test/fpsc_host_model.sv
`default_nettype none
module fpsc_host_model #(
  parameter int unsigned BAUD_DIV = 16
) (
  input  wire logic       clk,
  input  wire logic [8:0] row_drive_n,
  output logic [7:0]      col_sense_n,
  input  wire logic       mux_probe_mode,
  input  wire logic       mux_bank,
  input  wire logic [2:0] mux_ch,
  input  wire logic       adc_start,
  output logic            adc_done,
  output logic [7:0]      adc_result,
  input  wire logic       txd,
  output logic            rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [71:0] closed;
  logic [7:0]  pot_v [10];
  logic [7:0]  probe_v [4];
  logic [7:0]  rx_q [$];
  logic [7:0]  pick;
  assign pick = mux_probe_mode ? probe_v[mux_ch[1:0]] : pot_v[{mux_bank, mux_ch}];
  // open columns float up through the pull-ups
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      col_sense_n[c] = 1'b1;
      for (int r = 0; r < 9; r++) begin
        if (!row_drive_n[r] && closed[r*8+c]) col_sense_n[c] = 1'b0;
      end
    end
  end
  // converter answers after a random wait, then leaves junk on the bus
  initial begin
    adc_done = 1'b0;
    adc_result = 8'h00;
    rxd = 1'b1;
    forever begin
      @(posedge clk iff adc_start);
      repeat ($urandom_range(16, 1)) @(negedge clk);
      adc_result = pick;
      adc_done = 1'b1;
      @(negedge clk);
      adc_done = 1'b0;
      adc_result = ~pick;
    end
  end
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BAUD_DIV / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge clk);
        b[i] = txd;
      end
      repeat (BAUD_DIV) @(posedge clk);
      if (txd) rx_q.push_back(b);
    end
  end
  task automatic send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      rxd = f[i];
      repeat (BAUD_DIV - 1) @(negedge clk);
    end
    @(negedge clk);
    rxd = 1'b1;
    repeat (2 * BAUD_DIV) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/fpsc_panel_controller_tb.sv
`default_nettype none
module fpsc_panel_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpsc_pkg::*;
  localparam int unsigned BAUD = 16;
  logic       mclk, rst, mux_pm, mux_bank, adc_start, adc_done, txd, rxd, comp_sq, jit_ref;
  logic [8:0] row_n;
  logic [7:0] col_n, adc_res, led, exp_led, b;
  logic [2:0] mux_ch;
  logic [71:0] st_sw;
  logic [7:0] st_pot [10];
  logic [1:0] st_cls [4];
  logic [3:0] st_seen;
  logic [7:0] exp_q [$];
  int         error_cnt = 0;
  int         n_compared = 0;
  fpsc_panel_controller #(.BAUD_DIV(BAUD), .TIMER_DIV(40)) dut_u (
    .MCLK(mclk), .RST(rst), .ROW_DRIVE_N(row_n), .COL_SENSE_N(col_n),
    .MUX_PROBE_MODE(mux_pm), .MUX_BANK(mux_bank), .MUX_CH(mux_ch), .ADC_START(adc_start),
    .ADC_DONE(adc_done), .ADC_RESULT(adc_res), .TXD(txd), .RXD(rxd), .LED_LATCH(led),
    .PROBE_COMP_SQUARE(comp_sq), .ANALOG_JITTER_REF(jit_ref));
  fpsc_host_model #(.BAUD_DIV(BAUD)) host_u (
    .clk(mclk), .row_drive_n(row_n), .col_sense_n(col_n), .mux_probe_mode(mux_pm),
    .mux_bank(mux_bank), .mux_ch(mux_ch), .adc_start(adc_start), .adc_done(adc_done),
    .adc_result(adc_res), .txd(txd), .rxd(rxd));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk_rep(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t report byte got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_led(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t led latch got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [1:0] cls_of(input logic [7:0] v);
    return (v < PROBE_TH1) ? 2'd0 : (v < PROBE_TH2) ? 2'd1 : (v < PROBE_TH3) ? 2'd2 : 2'd3;
  endfunction
  // expected reports of one round, in scan order, against the stored state
  function automatic void plan_round();
    int d;
    int m;
    logic [1:0] c;
    for (int i = 0; i < 72; i++) begin
      if (host_u.closed[i] !== st_sw[i]) begin
        exp_q.push_back(TAG_SWITCH);
        exp_q.push_back({host_u.closed[i], 7'(i)});
      end
    end
    st_sw = host_u.closed;
    for (int p = 0; p < 10; p++) begin
      d = int'(host_u.pot_v[p]) - int'(st_pot[p]);
      m = (d < 0) ? -d : d;
      if (m > 127) m = 127;
      if (m != 0) begin
        exp_q.push_back(TAG_POT | 8'(p));
        exp_q.push_back({d < 0, 7'(m)});
      end
      st_pot[p] = host_u.pot_v[p];
    end
    for (int k = 0; k < 4; k++) begin
      c = cls_of(host_u.probe_v[k]);
      if (!st_seen[k] || c != st_cls[k]) begin
        exp_q.push_back(TAG_PROBE | 8'(k));
        exp_q.push_back({6'h00, c});
      end
      st_seen[k] = 1'b1;
      st_cls[k] = c;
    end
  endfunction
  // corners: edge switches flip, a pot swings past full scale, a probe sits on a threshold
  task automatic shuffle(input int r);
    @(negedge mclk);
    for (int i = 0; i < 72; i++) host_u.closed[i] = ($urandom_range(7) == 0);
    for (int p = 0; p < 10; p++) host_u.pot_v[p] = 8'($urandom);
    for (int k = 0; k < 4; k++) host_u.probe_v[k] = 8'($urandom);
    host_u.pot_v[0] = st_pot[0];
    host_u.pot_v[1] = r[0] ? 8'h05 : 8'hF0;
    host_u.closed[0] = !r[0];
    host_u.closed[71] = r[0];
    host_u.probe_v[3] = r[0] ? 8'h3F : 8'h40;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h6890_0263));
    rst = 1'b1;
    st_sw = '0;
    st_seen = 4'h0;
    exp_led = LED_RESET;
    for (int p = 0; p < 10; p++) st_pot[p] = 8'h00;
    for (int k = 0; k < 4; k++) st_cls[k] = 2'd0;
    shuffle(0);
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    for (int r = 0; r < 3; r++) begin
      plan_round();
      @(negedge mux_pm);
      // last frame may still be on the wire; row 0 is sampled well after this
      repeat (12 * BAUD) @(negedge mclk);
      chk_rep(8'(host_u.rx_q.size()), 8'(exp_q.size()));
      while (exp_q.size() > 0 && host_u.rx_q.size() > 0) begin
        chk_rep(host_u.rx_q.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      host_u.rx_q.delete();
      shuffle(r + 1);
    end
    for (int i = 0; i < 10; i++) begin
      b = 8'($urandom);
      if (i < 8) b[2:0] = 3'(i);
      host_u.send_byte(b, i != 8);
      if (i != 8 && b[2:0] < 3'h5) exp_led[b[2:0]] = !b[7];
      chk_led(led, exp_led);
    end
    tally_and_finish();
  end
  // about three scan rounds with reports plus the led frames take under 50k cycles
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
